// file: logic/adcr_pkg.sv
package adcr_pkg;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 20;
  localparam int unsigned CONV_TIME_US   = 1000;
  localparam int unsigned WAKE_DELAY_US  = 100;
  localparam int unsigned POR_DELAY_US   = 300;
  localparam int unsigned CONV_CYCLES    = CONV_TIME_US * CLK_MHZ;
  localparam int unsigned WAKE_CYCLES    = WAKE_DELAY_US * CLK_MHZ;
  localparam int unsigned POR_CYCLES     = POR_DELAY_US * CLK_MHZ;

  // ------------------------------------------------------------
  // result word
  // ------------------------------------------------------------
  localparam int unsigned WORD_BITS      = 24;
  localparam int unsigned OVL_BIT        = 23;
  localparam int unsigned OVH_BIT        = 22;
  localparam int unsigned SIGN_BIT       = 21;
  localparam logic [4:0]  LAST_BIT_CNT   = 5'h18;
  localparam logic [4:0]  RELEASE_CNT    = 5'h19;

  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0]  SAMPLE_OFS     = 8'h00;
  localparam logic [7:0]  STATUS_OFS     = 8'h04;
  localparam logic [23:0] SAMPLE_RST     = 24'h000000;
  localparam int unsigned ST_STATE_LSB   = 0;
  localparam int unsigned ST_SINGLE_BIT  = 4;
  localparam int unsigned ST_READY_BIT   = 5;
  localparam int unsigned ST_PEND_BIT    = 6;
  localparam int unsigned ST_CNT_LSB     = 8;

  typedef enum logic [2:0] {
    ST_PWRON, ST_SHUTDOWN, ST_WAKE, ST_CONVERT, ST_SLEEP
  } adcr_state_t;

endpackage

// file: logic/adcr_top.sv
// Chosen here: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module adcr_top
  import adcr_pkg::*;
#(
  parameter int unsigned CONV_CNT = adcr_pkg::CONV_CYCLES,
  parameter int unsigned WAKE_CNT = adcr_pkg::WAKE_CYCLES,
  parameter int unsigned POR_CNT  = adcr_pkg::POR_CYCLES
) (
  input  wire logic        CLK,
  input  wire logic        RST_N,
  input  wire logic        CS_N,
  input  wire logic        SCK,
  output logic             SDO_O,
  output logic             SDO_OE,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR
);
  import adcr_pkg::*;

  // ------------------------------------------------------------
  // decoding helpers
  // ------------------------------------------------------------

  // bus address selects the given register
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] ofs);
    return addr == ofs;
  endfunction

  // status word as software reads it
  function automatic logic [31:0] status_word(input adcr_state_t st,
                                              input logic        sgl,
                                              input logic        rdy,
                                              input logic        pnd,
                                              input logic [4:0]  cnt);
    logic [31:0] w;
    w                     = 32'h00000000;
    w[ST_STATE_LSB +: 3]  = st;
    w[ST_SINGLE_BIT]      = sgl;
    w[ST_READY_BIT]       = rdy;
    w[ST_PEND_BIT]        = pnd;
    w[ST_CNT_LSB +: 5]    = cnt;
    return w;
  endfunction

  // buffer bit shown after cnt serial clock falls, msb first
  function automatic logic word_bit(input logic [23:0] word,
                                    input logic [4:0]  cnt);
    return word[LAST_BIT_CNT - cnt];
  endfunction

  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic sck_meta;
  logic sck_sync;
  logic sck_prev;
  logic cs_fall;
  logic cs_rise;
  logic sck_fall;

  // select resets to its idle level so no false edge follows reset
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= CS_N;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  // serial clock, only its falls are used
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sck_meta <= 1'b0;
      sck_sync <= 1'b0;
      sck_prev <= 1'b0;
    end else begin
      sck_meta <= SCK;
      sck_sync <= sck_meta;
      sck_prev <= sck_sync;
    end
  end

  assign cs_fall  = cs_prev & ~cs_sync;
  assign cs_rise  = ~cs_prev & cs_sync;
  assign sck_fall = sck_prev & ~sck_sync & ~cs_sync;

  // ------------------------------------------------------------
  // apb registers
  // ------------------------------------------------------------
  logic [23:0]  sample;
  adcr_state_t  state;
  logic         single;
  logic         data_ready;
  logic         pending;
  logic [4:0]   bit_cnt;
  logic         apb_hit;
  logic         addr_ok;

  assign addr_ok = reg_hit(PADDR, SAMPLE_OFS) || reg_hit(PADDR, STATUS_OFS);
  assign apb_hit = PSEL & PENABLE;
  assign PREADY  = 1'b1;
  assign PSLVERR = apb_hit & ~addr_ok;

  // sample word written over APB, taken as the result at the end of each conversion, except a single conversion that ends with select high
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      sample <= SAMPLE_RST;
    end else if (apb_hit && PWRITE && reg_hit(PADDR, SAMPLE_OFS)) begin
      sample <= PWDATA[23:0];
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      PRDATA <= 32'h00000000;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      if (reg_hit(PADDR, SAMPLE_OFS)) begin
        PRDATA <= {8'h00, sample};
      end else if (reg_hit(PADDR, STATUS_OFS)) begin
        PRDATA <= status_word(state, single, data_ready, pending, bit_cnt);
      end else begin
        // unmapped reads return zero
        PRDATA <= 32'h00000000;
      end
    end
  end

  // ------------------------------------------------------------
  // conversion sequencer
  // ------------------------------------------------------------
  logic [31:0] timer;
  logic        rise_seen;
  logic        conv_done;
  logic        shifting;
  logic        word_done;

  assign conv_done = (state == ST_CONVERT) && (timer == CONV_CNT - 1);
  assign shifting  = (bit_cnt != 5'h00);
  assign word_done = sck_fall && (bit_cnt == LAST_BIT_CNT);

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      state     <= ST_PWRON;
      timer     <= 32'h00000000;
      single    <= 1'b0;
      rise_seen <= 1'b0;
    end else begin
      unique case (state)
        ST_PWRON: begin
          if (cs_sync) begin
            state <= ST_SHUTDOWN;
            timer <= 32'h00000000;
          end else if (timer == POR_CNT - 1) begin
            state  <= ST_CONVERT;
            timer  <= 32'h00000000;
            single <= 1'b0;
          end else begin
            timer <= timer + 32'h00000001;
          end
        end
        ST_SHUTDOWN: begin
          timer <= 32'h00000000;
          if (cs_fall) begin
            state     <= ST_WAKE;
            single    <= 1'b0;
            rise_seen <= 1'b0;
          end
        end
        ST_WAKE: begin
          if (cs_rise) begin
            state <= ST_SHUTDOWN;
          end else if (timer == WAKE_CNT - 1) begin
            state <= ST_CONVERT;
            timer <= 32'h00000000;
          end else begin
            timer <= timer + 32'h00000001;
          end
        end
        ST_CONVERT: begin
          // a rise is noted but the conversion always runs out
          if (cs_rise) begin
            rise_seen <= 1'b1;
            single    <= 1'b1;
          end
          if (conv_done) begin
            timer     <= 32'h00000000;
            rise_seen <= 1'b0;
            if (rise_seen || cs_rise) begin
              // later fall in this conversion starts nothing
              state <= cs_sync ? ST_SHUTDOWN : ST_SLEEP;
            end else begin
              state <= ST_CONVERT;
            end
          end else begin
            timer <= timer + 32'h00000001;
          end
        end
        ST_SLEEP: begin
          if (cs_rise) begin
            state <= ST_SHUTDOWN;
          end
        end
        default: begin
          state <= ST_SHUTDOWN;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // output buffer and shifter
  // ------------------------------------------------------------
  logic [23:0] out_buf;
  logic [23:0] pend_buf;
  logic        discard;
  logic        drop_all;

  // rise outside a conversion ends everything, also mid-word
  assign discard = cs_rise && (state != ST_CONVERT);

  // single conversion ending with select high loses its result
  assign drop_all = discard || (conv_done && cs_sync && (rise_seen || cs_rise));

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      out_buf    <= 24'h000000;
      pend_buf   <= 24'h000000;
      data_ready <= 1'b0;
      pending    <= 1'b0;
      bit_cnt    <= 5'h00;
    end else if (drop_all) begin
      data_ready <= 1'b0;
      pending    <= 1'b0;
      bit_cnt    <= 5'h00;
    end else begin
      if (conv_done) begin
        if (shifting) begin
          pend_buf <= sample;
          pending  <= 1'b1;
        end else begin
          out_buf    <= sample;
          data_ready <= 1'b1;
        end
      end
      if (sck_fall && data_ready && !(conv_done && !shifting)) begin
        if (word_done) begin
          // a result landing on the 25th fall is kept, not dropped
          bit_cnt    <= 5'h00;
          data_ready <= pending | conv_done;
          pending    <= 1'b0;
          if (conv_done) begin
            out_buf <= sample;
          end else if (pending) begin
            out_buf <= pend_buf;
          end
        end else begin
          bit_cnt <= bit_cnt + 5'h01;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // shared data / ready pin
  // ------------------------------------------------------------
  logic busy_latch;
  logic ready_n;

  // single mode latches status at each select fall
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      busy_latch <= 1'b1;
    end else if (cs_fall) begin
      busy_latch <= (state != ST_SLEEP) && !data_ready;
    end else if (conv_done) begin
      busy_latch <= 1'b0;
    end
  end

  assign ready_n = single ? (busy_latch | ~data_ready) : ~data_ready;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SDO_OE <= 1'b0;
    end else begin
      SDO_OE <= ~cs_sync;
    end
  end

  // data bits while a word is out, ready status otherwise
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      SDO_O <= 1'b1;
    end else if (shifting && bit_cnt <= LAST_BIT_CNT) begin
      SDO_O <= word_bit(out_buf, bit_cnt);
    end else begin
      SDO_O <= ready_n;
    end
  end

endmodule

// file: tb/adcr_checker.sv
`timescale 1ns/1ps
module adcr_checker #(
  parameter int unsigned CONV_CNT = 50,
  parameter int unsigned WAKE_CNT = 10
) (
  input wire logic       CLK,
  input wire logic       RST_N,
  input wire logic       CS_N,
  input wire logic       SDO_O,
  input wire logic       SDO_OE,
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic       PREADY,
  input wire logic       PSLVERR
);
  import adcr_pkg::*;
  localparam int T_DONE = WAKE_CNT + CONV_CNT;
  localparam int T_LONG = T_DONE + 16;
  logic [15:0] hi_cnt;
  logic [15:0] lo_cnt;
  logic        armed;
  logic        bad;
  assign bad = PADDR != SAMPLE_OFS && PADDR != STATUS_OFS;
  // armed: select fell after a long idle, so a fresh conversion runs
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      hi_cnt <= 16'hFFFF;
      lo_cnt <= 16'h0000;
      armed  <= 1'b0;
    end else if (CS_N) begin
      hi_cnt <= hi_cnt + 16'(hi_cnt != 16'hFFFF);
      lo_cnt <= 16'h0000;
      armed  <= 1'b0;
    end else begin
      hi_cnt <= 16'h0000;
      lo_cnt <= lo_cnt + 16'(lo_cnt != 16'hFFFF);
      if (lo_cnt == 16'h0000) armed <= 32'(hi_cnt) >= T_LONG;
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  sequence s_rd_setup(logic [7:0] a);
    PSEL && !PENABLE && !PWRITE && PADDR == a;
  endsequence
  a_pin_released : assert property (CS_N [*6] |-> !SDO_OE)
    else $error("data pin driven while deselected");
  a_pin_driven : assert property ((!CS_N) [*6] |-> SDO_OE)
    else $error("data pin not driven while selected");
  a_busy_conv : assert property (armed && 32'(lo_cnt) < T_DONE && SDO_OE |-> SDO_O)
    else $error("ready shown before conversion end");
  a_ready_time : assert property (armed && 32'(lo_cnt) == T_DONE + 8 |-> SDO_OE && !SDO_O)
    else $error("ready late after conversion");
  a_zero_wait : assert property (PSEL && PENABLE |-> PREADY)
    else $error("access phase stalled");
  a_slverr_bad : assert property (PSEL && PENABLE && bad |-> PSLVERR)
    else $error("unmapped access not refused");
  a_slverr_good : assert property (PSEL && PENABLE && !bad |-> !PSLVERR)
    else $error("mapped access refused");
  a_refused_zero : assert property (PSEL && !PENABLE && !PWRITE && bad |=> PRDATA == 32'h0)
    else $error("unmapped read data not zero");
  a_sample_upper : assert property (s_rd_setup(SAMPLE_OFS) |=> PRDATA[31:24] == 8'h00)
    else $error("sample upper byte not zero");
endmodule
bind adcr_top adcr_checker #(.CONV_CNT(CONV_CNT), .WAKE_CNT(WAKE_CNT)) adcr_checker_i (
  .CLK(CLK), .RST_N(RST_N), .CS_N(CS_N), .SDO_O(SDO_O), .SDO_OE(SDO_OE), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY),
  .PSLVERR(PSLVERR));

// file: tb/adcr_host.sv
`timescale 1ns/1ps
module adcr_host (
  input  wire logic CLK,
  input  wire logic SDO_O,
  input  wire logic SDO_OE,
  output logic      CS_N,
  output logic      SCK
);
  logic flip;
  logic pin;
  // released line shows a changing level, never the last bit
  always @(posedge CLK) flip <= ~flip;
  assign pin = SDO_OE ? SDO_O : flip;
  initial begin
    flip = 1'b0;
    CS_N = 1'b1;
    SCK  = 1'b1;
  end
  task automatic sel(input logic v);
    CS_N <= v;
    @(posedge CLK);
  endtask
  // shift on fall, sample late in the high phase
  task automatic shift(input int n, inout logic [23:0] w);
    for (int i = 0; i < n; i++) begin
      SCK <= 1'b0;
      repeat (4) @(posedge CLK);
      SCK <= 1'b1;
      repeat (4) @(posedge CLK);
      w = {w[22:0], pin};
    end
  endtask
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
module tb;
  import adcr_pkg::*;
  logic        CLK;
  logic        RST_N;
  logic        CS_N;
  logic        SCK;
  logic        SDO_O;
  logic        SDO_OE;
  logic        PSEL;
  logic        PENABLE;
  logic        PWRITE;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA;
  logic [31:0] PRDATA;
  logic        PREADY;
  logic        PSLVERR;
  int          fail_count;
  int          n_tests;
  int          cyc;
  logic [31:0] rd;
  logic        err;
  logic [23:0] w;
  logic [23:0] v;
  adcr_top #(.CONV_CNT(50), .WAKE_CNT(10), .POR_CNT(20)) adcr_top_i (.CLK(CLK), .RST_N(RST_N),
    .CS_N(CS_N), .SCK(SCK), .SDO_O(SDO_O), .SDO_OE(SDO_OE), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR));
  adcr_host adcr_host_i (.CLK(CLK), .SDO_O(SDO_O), .SDO_OE(SDO_OE), .CS_N(CS_N), .SCK(SCK));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end
  function automatic logic [23:0] frame(input logic overflow_low_flag, input logic overflow_high_flag, input logic [21:0] c);
    return {overflow_low_flag, overflow_high_flag, c};
  endfunction
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    PSEL   <= 1'b1;
    PWRITE <= wr;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  task automatic st(input logic [2:0] s);
    apb(1'b0, STATUS_OFS, 32'h0);
    chk("state", {29'h0, s}, rd & 32'h7);
  endtask
  task automatic wrdy();
    repeat (6) @(posedge CLK);
    while (adcr_host_i.pin !== 1'b0) @(posedge CLK);
    repeat (10) @(posedge CLK);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  initial begin
    RST_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    fail_count = 0;
    n_tests = 0;
    cyc = 0;
    void'($urandom(68));
    repeat (10) @(posedge CLK);
    RST_N <= 1'b1;
    repeat (6) @(posedge CLK);
    chk("oe idle", 32'h0, 32'(SDO_OE));
    apb(1'b1, 8'h08, 32'hFFFFFFFF);
    chk("slverr", 32'h1, 32'(err));
    apb(1'b0, 8'h08, 32'h0);
    chk("bad rd", 32'h0, rd);
    st(3'h1);
    for (int i = 0; i < 4; i++) begin
      v = frame(i[1], i[0], 22'($urandom));
      apb(1'b1, SAMPLE_OFS, {8'h00, v});
      apb(1'b0, SAMPLE_OFS, 32'h0);
      chk("sample", {8'h00, v}, rd);
      adcr_host_i.sel(1'b0);
      w = 24'h0;
      adcr_host_i.shift(2, w);
      chk("busy", 32'h3, 32'(w[1:0]));
      wrdy();
      adcr_host_i.shift(12, w);
      apb(1'b1, SAMPLE_OFS, {8'h00, ~v});
      adcr_host_i.shift(12, w);
      chk("word", {8'h00, v}, 32'(w));
      adcr_host_i.shift(1, w);
      chk("pending", 32'h0, 32'(w[0]));
      adcr_host_i.shift(24, w);
      chk("newest", {8'h00, ~v}, 32'(w));
      adcr_host_i.sel(1'b1);
      repeat (120) @(posedge CLK);
      st(3'h1);
    end
    adcr_host_i.sel(1'b0);
    repeat (20) @(posedge CLK);
    adcr_host_i.sel(1'b1);
    repeat (5) @(posedge CLK);
    adcr_host_i.sel(1'b0);
    repeat (6) @(posedge CLK);
    chk("latched", 32'h1, 32'(adcr_host_i.pin));
    wrdy();
    adcr_host_i.shift(24, w);
    chk("single", {8'h00, ~v}, 32'(w));
    adcr_host_i.shift(1, w);
    chk("end pin", 32'h1, 32'(w[0]));
    repeat (120) @(posedge CLK);
    st(3'h4);
    adcr_host_i.sel(1'b1);
    repeat (4) @(posedge CLK);
    st(3'h1);
    adcr_host_i.sel(1'b0);
    wrdy();
    w = 24'h0;
    adcr_host_i.shift(10, w);
    chk("partial", 32'(v[23:14] ^ 10'h3FF), 32'(w[9:0]));
    adcr_host_i.sel(1'b1);
    repeat (120) @(posedge CLK);
    st(3'h1);
    close_out();
  end
endmodule
